// ==== hdl/serial_dma_pointers.v ====
// Operation
// - 14-bit transmit offset of next fetched byte
// - Offsets clear on buffer load and DMA reset
// - Receive A offset advances per stored byte
// - Receive B offset advances per stored byte
// - Receive offset write to unloaded buffer loads it
// - Receive A start address, RAM base reset
// - Receive B start address, RAM base reset
// - Receive A end address, last written byte
// - Receive B end address, last written byte
// - Transmit B end address, last fetched byte
`include "dma_ptr_map.vh"

module serial_dma_pointers #(
  parameter FW = 14
) (
  input  wire          clk,
  input  wire          rst,
  input  wire [31:0]   avs_address,
  input  wire          avs_read,
  input  wire          avs_write,
  input  wire [31:0]   avs_writedata,
  input  wire [3:0]    avs_byteenable,
  output reg  [31:0]   avs_readdata,
  output wire          avs_waitrequest,
  input  wire          rx_put,
  output wire          rx_avail,
  output reg  [31:0]   rx_addr_reg,
  input  wire          tx_take,
  output wire          tx_avail,
  output reg  [31:0]   tx_addr_reg,
  input  wire [FW-1:0] tx_a_start,
  input  wire [FW-1:0] tx_a_end,
  input  wire [FW-1:0] tx_b_start
);

  // Byte-lane merge of a 14-bit field
  function [FW-1:0] merge_field;
    input [FW-1:0] old;
    input [31:0]   wd;
    input [3:0]    be;
    reg   [FW-1:0] tmp;
    begin
      tmp = old;
      if (be[0]) begin
        tmp[7:0] = wd[7:0];
      end
      if (be[1]) begin
        tmp[FW-1:8] = wd[FW-1:8];
      end
      merge_field = tmp;
    end
  endfunction

  // Upper address bits are fixed; only the field is programmable
  function [31:0] ram_addr;
    input [FW-1:0] field;
    begin
      ram_addr = `RAM_BASE | {{(32-FW){1'b0}}, field};
    end
  endfunction

  reg            ack_reg;
  reg  [FW-1:0]  rx_a_start_reg;
  reg  [FW-1:0]  rx_a_end_reg;
  reg  [FW-1:0]  rx_b_start_reg;
  reg  [FW-1:0]  rx_b_end_reg;
  reg  [FW-1:0]  tx_b_end_reg;
  reg  [1:0]     rx_loaded_reg;
  reg  [1:0]     rx_loaded_next;
  reg            rx_sel_reg;
  reg            rx_sel_next;
  reg  [1:0]     tx_loaded_reg;
  reg  [1:0]     tx_loaded_next;
  reg            tx_sel_reg;
  reg            tx_sel_next;
  reg  [31:0]    read_value;
  wire           wr_go;
  wire           rd_start;
  wire           ctrl_wr;
  wire           rx_rst;
  wire           tx_rst;
  wire [1:0]     rx_load_req;
  wire [1:0]     rx_load;
  wire [1:0]     tx_load;
  wire           rx_step;
  wire           tx_step;
  wire [FW-1:0]  rx_a_cnt;
  wire [FW-1:0]  rx_b_cnt;
  wire [FW-1:0]  tx_cnt;
  wire [FW-1:0]  rx_a_cnt_next;
  wire [FW-1:0]  rx_b_cnt_next;
  wire [FW-1:0]  tx_cnt_next;
  wire [FW-1:0]  rx_cur_start;
  wire [FW-1:0]  rx_cur_end;
  wire [FW-1:0]  rx_cur_cnt;
  wire [FW-1:0]  rx_cur_addr;
  wire [FW-1:0]  tx_cur_start;
  wire [FW-1:0]  tx_cur_end;
  wire [FW-1:0]  tx_cur_addr;
  wire           rx_last;
  wire           tx_last;
  wire           tx_clear;
  wire [FW-1:0]  rx_nstart;
  wire [FW-1:0]  rx_ncnt;
  wire [FW-1:0]  tx_nstart;

  // One wait state: request is taken on the second edge after it rises
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_go           = avs_write & ack_reg;
  assign rd_start        = avs_read & ~ack_reg;

  always @(posedge clk) begin
    if (rst) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  // Control strobes are write-one pulses, nothing is stored
  assign ctrl_wr = wr_go & (avs_address == `ADDR_DMA_CTRL) &
                   avs_byteenable[0];
  assign rx_rst  = ctrl_wr & avs_writedata[`CTRL_RST_RX];
  assign tx_rst  = ctrl_wr & avs_writedata[`CTRL_RST_TX];

  assign rx_load_req[0] =
    (ctrl_wr & avs_writedata[`CTRL_LOAD_RX_A]) |
    (wr_go & (avs_address == `ADDR_RX_A_OFFSET));
  assign rx_load_req[1] =
    (ctrl_wr & avs_writedata[`CTRL_LOAD_RX_B]) |
    (wr_go & (avs_address == `ADDR_RX_B_OFFSET));
  // Loading an already loaded buffer is ignored
  assign rx_load = rx_load_req & ~rx_loaded_reg & {2{~rx_rst}};
  assign tx_load = {avs_writedata[`CTRL_LOAD_TX_B],
                    avs_writedata[`CTRL_LOAD_TX_A]} &
                   {2{ctrl_wr & ~tx_rst}} & ~tx_loaded_reg;

  // Address and end registers, software written
  always @(posedge clk) begin
    if (rst) begin
      rx_a_start_reg <= `FIELD_RESET;
      rx_a_end_reg   <= `FIELD_RESET;
      rx_b_start_reg <= `FIELD_RESET;
      rx_b_end_reg   <= `FIELD_RESET;
      tx_b_end_reg   <= `FIELD_RESET;
    end else if (wr_go) begin
      if (avs_address == `ADDR_RX_A_START) begin
        rx_a_start_reg <= merge_field(rx_a_start_reg, avs_writedata,
                                      avs_byteenable);
      end else if (avs_address == `ADDR_RX_A_END) begin
        rx_a_end_reg <= merge_field(rx_a_end_reg, avs_writedata,
                                    avs_byteenable);
      end else if (avs_address == `ADDR_RX_B_START) begin
        rx_b_start_reg <= merge_field(rx_b_start_reg, avs_writedata,
                                      avs_byteenable);
      end else if (avs_address == `ADDR_RX_B_END) begin
        rx_b_end_reg <= merge_field(rx_b_end_reg, avs_writedata,
                                    avs_byteenable);
      end else if (avs_address == `ADDR_TX_B_END) begin
        tx_b_end_reg <= merge_field(tx_b_end_reg, avs_writedata,
                                    avs_byteenable);
      end
    end
  end

  // Receive side: active buffer view
  assign rx_cur_start = rx_sel_reg ? rx_b_start_reg : rx_a_start_reg;
  assign rx_cur_end   = rx_sel_reg ? rx_b_end_reg : rx_a_end_reg;
  assign rx_cur_cnt   = rx_sel_reg ? rx_b_cnt : rx_a_cnt;
  assign rx_cur_addr  = rx_cur_start + rx_cur_cnt;
  assign rx_avail     = rx_loaded_reg[rx_sel_reg];
  assign rx_step      = rx_put & rx_avail & ~rx_rst;
  assign rx_last      = rx_step & (rx_cur_addr == rx_cur_end);

  // Receive loaded flags and buffer selection
  always @* begin
    rx_loaded_next = rx_loaded_reg | rx_load;
    rx_sel_next    = rx_sel_reg;
    if (rx_rst) begin
      rx_loaded_next = 2'h0;
      rx_sel_next    = 1'b0;
    end else if (rx_last) begin
      rx_loaded_next[rx_sel_reg] = 1'b0;
      rx_sel_next                = ~rx_sel_reg;
    end else if (~rx_avail & rx_loaded_reg[~rx_sel_reg]) begin
      rx_sel_next = ~rx_sel_reg;
    end
  end

  offset_counter #(
    .W          (FW)
  ) u_rx_a_cnt (
    .clk        (clk),
    .rst        (rst),
    .clear      (rx_rst | rx_load[0]),
    .advance    (rx_step & ~rx_sel_reg),
    .count_next (rx_a_cnt_next),
    .count_reg  (rx_a_cnt)
  );

  offset_counter #(
    .W          (FW)
  ) u_rx_b_cnt (
    .clk        (clk),
    .rst        (rst),
    .clear      (rx_rst | rx_load[1]),
    .advance    (rx_step & rx_sel_reg),
    .count_next (rx_b_cnt_next),
    .count_reg  (rx_b_cnt)
  );

  // Transmit side: active buffer view
  assign tx_cur_start = tx_sel_reg ? tx_b_start : tx_a_start;
  assign tx_cur_end   = tx_sel_reg ? tx_b_end_reg : tx_a_end;
  assign tx_cur_addr  = tx_cur_start + tx_cnt;
  assign tx_avail     = tx_loaded_reg[tx_sel_reg];
  assign tx_step      = tx_take & tx_avail & ~tx_rst;
  assign tx_last      = tx_step & (tx_cur_addr == tx_cur_end);

  // Transmit loaded flags and buffer selection
  always @* begin
    tx_loaded_next = tx_loaded_reg | tx_load;
    tx_sel_next    = tx_sel_reg;
    if (tx_rst) begin
      tx_loaded_next = 2'h0;
      tx_sel_next    = 1'b0;
    end else if (tx_last) begin
      tx_loaded_next[tx_sel_reg] = 1'b0;
      tx_sel_next                = ~tx_sel_reg;
    end else if (~tx_avail & tx_loaded_reg[~tx_sel_reg]) begin
      tx_sel_next = ~tx_sel_reg;
    end
  end

  // new active buffer starts at zero
  assign tx_clear = tx_rst | tx_last | (tx_sel_next != tx_sel_reg) |
                    tx_load[tx_sel_reg];

  offset_counter #(
    .W          (FW)
  ) u_tx_cnt (
    .clk        (clk),
    .rst        (rst),
    .clear      (tx_clear),
    .advance    (tx_step),
    .count_next (tx_cnt_next),
    .count_reg  (tx_cnt)
  );

  // State flops for both directions
  always @(posedge clk) begin
    if (rst) begin
      rx_loaded_reg <= 2'h0;
      rx_sel_reg    <= 1'b0;
      tx_loaded_reg <= 2'h0;
      tx_sel_reg    <= 1'b0;
    end else begin
      rx_loaded_reg <= rx_loaded_next;
      rx_sel_reg    <= rx_sel_next;
      tx_loaded_reg <= tx_loaded_next;
      tx_sel_reg    <= tx_sel_next;
    end
  end

  // Next-cycle addresses, so the registered outputs lag nothing but a start change, by one cycle
  assign rx_nstart = rx_sel_next ? rx_b_start_reg : rx_a_start_reg;
  assign rx_ncnt   = rx_sel_next ? rx_b_cnt_next : rx_a_cnt_next;
  assign tx_nstart = tx_sel_next ? tx_b_start : tx_a_start;

  always @(posedge clk) begin
    if (rst) begin
      rx_addr_reg <= `RAM_BASE;
      tx_addr_reg <= `RAM_BASE;
    end else begin
      rx_addr_reg <= ram_addr(rx_nstart + rx_ncnt);
      tx_addr_reg <= ram_addr(tx_nstart + tx_cnt_next);
    end
  end

  // Read decode; unmapped addresses read as zero
  always @* begin
    if (avs_address == `ADDR_RX_A_START) begin
      read_value = ram_addr(rx_a_start_reg);
    end else if (avs_address == `ADDR_RX_A_END) begin
      read_value = ram_addr(rx_a_end_reg);
    end else if (avs_address == `ADDR_RX_B_START) begin
      read_value = ram_addr(rx_b_start_reg);
    end else if (avs_address == `ADDR_RX_B_END) begin
      read_value = ram_addr(rx_b_end_reg);
    end else if (avs_address == `ADDR_TX_B_END) begin
      read_value = ram_addr(tx_b_end_reg);
    end else if (avs_address == `ADDR_RX_A_OFFSET) begin
      read_value = {{(32-FW){1'b0}}, rx_a_cnt};
    end else if (avs_address == `ADDR_RX_B_OFFSET) begin
      read_value = {{(32-FW){1'b0}}, rx_b_cnt};
    end else if (avs_address == `ADDR_TX_OFFSET) begin
      read_value = {{(32-FW){1'b0}}, tx_cnt};
    end else if (avs_address == `ADDR_DMA_STATUS) begin
      read_value = 32'h00000000;
      read_value[`STAT_RX_LOADED_A] = rx_loaded_reg[0];
      read_value[`STAT_RX_LOADED_B] = rx_loaded_reg[1];
      read_value[`STAT_RX_SEL]      = rx_sel_reg;
      read_value[`STAT_TX_LOADED_A] = tx_loaded_reg[0];
      read_value[`STAT_TX_LOADED_B] = tx_loaded_reg[1];
      read_value[`STAT_TX_SEL]      = tx_sel_reg;
    end else begin
      read_value = 32'h00000000;
    end
  end

  // Read data captured on the wait edge and held for the taking edge
  always @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_start) begin
      avs_readdata <= read_value;
    end
  end

endmodule

// ==== include/dma_ptr_map.vh ====
`ifndef DMA_PTR_MAP_VH
`define DMA_PTR_MAP_VH

// Register byte addresses on the processor bus
`define ADDR_RX_A_START   32'h4000C800
`define ADDR_RX_A_END     32'h4000C804
`define ADDR_RX_B_START   32'h4000C808
`define ADDR_RX_B_END     32'h4000C80C
`define ADDR_TX_B_END     32'h4000C81C
`define ADDR_RX_A_OFFSET  32'h4000C820
`define ADDR_RX_B_OFFSET  32'h4000C824
`define ADDR_TX_OFFSET    32'h4000C828
`define ADDR_DMA_CTRL     32'h4000C840
`define ADDR_DMA_STATUS   32'h4000C844

// Address and offset field
`define FIELD_W           14
`define FIELD_RESET       14'h0000
`define RAM_BASE          32'h20000000
`define OFFSET_RESET      14'h0000

// Control register bits, write one to act
`define CTRL_LOAD_RX_A    0
`define CTRL_LOAD_RX_B    1
`define CTRL_LOAD_TX_A    2
`define CTRL_LOAD_TX_B    3
`define CTRL_RST_RX       4
`define CTRL_RST_TX       5

// Status register fields
`define STAT_RX_LOADED_A  0
`define STAT_RX_LOADED_B  1
`define STAT_RX_SEL       2
`define STAT_TX_LOADED_A  3
`define STAT_TX_LOADED_B  4
`define STAT_TX_SEL       5

`endif

// ==== hdl/offset_counter.v ====
module offset_counter #(
  parameter W = 14
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         clear,
  input  wire         advance,
  output wire [W-1:0] count_next,
  output reg  [W-1:0] count_reg
);

  // Clear has priority so a load in the same cycle starts at zero
  assign count_next = clear   ? {W{1'b0}} :
                      advance ? count_reg + {{(W-1){1'b0}}, 1'b1} :
                      count_reg;

  // Offset storage
  always @(posedge clk) begin
    if (rst) begin
      count_reg <= {W{1'b0}};
    end else begin
      count_reg <= count_next;
    end
  end

endmodule

// ==== tb/serial_side_model.sv ====
// Stand-in for the shift logic: moves a byte whenever enabled and a buffer is ready, every other cycle when slow
module serial_side_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic rx_en,
  input  wire logic tx_en,
  input  wire logic slow,
  input  wire logic rx_avail,
  input  wire logic tx_avail,
  output logic      rx_put,
  output logic      tx_take
);
  timeunit 1ns;
  timeprecision 1ps;

  // Registered strobes lag avail, so a late refused pulse can occur
  always @(posedge clk) begin
    rx_put  <= !rst && rx_en && rx_avail && !(slow && rx_put);
    tx_take <= !rst && tx_en && tx_avail && !(slow && tx_take);
  end
endmodule

// ==== tb/serial_dma_pointers_asserts.sv ====
`include "dma_ptr_map.vh"
module serial_dma_pointers_asserts #(
  parameter FW = 14
) (
  input wire          clk,
  input wire          rst,
  input wire [31:0]   avs_address,
  input wire          avs_read,
  input wire          avs_write,
  input wire [31:0]   avs_writedata,
  input wire [3:0]    avs_byteenable,
  input wire          avs_waitrequest,
  input wire          rx_put,
  input wire          rx_avail,
  input wire [31:0]   rx_addr_reg,
  input wire          tx_take,
  input wire          tx_avail,
  input wire [31:0]   tx_addr_reg,
  input wire [FW-1:0] tx_a_end
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Byte-lane merge of a bus write into a mirrored field
  function automatic logic [FW-1:0] lanes(input logic [FW-1:0] old);
    lanes = old;
    if (avs_byteenable[0]) lanes[7:0] = avs_writedata[7:0];
    if (avs_byteenable[1]) lanes[FW-1:8] = avs_writedata[FW-1:8];
  endfunction

  // End fields mirrored from taken writes; a step may jump at an end
  logic [FW-1:0] rx_a_end_m, rx_b_end_m, tx_b_end_m;
  always @(posedge clk) begin
    if (rst) begin
      rx_a_end_m <= '0;
      rx_b_end_m <= '0;
      tx_b_end_m <= '0;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == `ADDR_RX_A_END) rx_a_end_m <= lanes(rx_a_end_m);
      if (avs_address == `ADDR_RX_B_END) rx_b_end_m <= lanes(rx_b_end_m);
      if (avs_address == `ADDR_TX_B_END) tx_b_end_m <= lanes(tx_b_end_m);
    end
  end

  property p_first_wait;
    $rose(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  property p_after_rst;
    $fell(rst) |-> rx_addr_reg == `RAM_BASE && !rx_avail && !tx_avail;
  endproperty
  property p_rx_step;
    rx_put && rx_avail && !avs_write ##1 rx_avail
      |-> rx_addr_reg[13:0] == $past(rx_addr_reg[13:0]) + 14'h1 ||
          $past(rx_addr_reg[13:0]) == rx_a_end_m ||
          $past(rx_addr_reg[13:0]) == rx_b_end_m;
  endproperty
  property p_tx_step;
    tx_take && tx_avail && !avs_write ##1 tx_avail
      |-> tx_addr_reg[13:0] == $past(tx_addr_reg[13:0]) + 14'h1 ||
          $past(tx_addr_reg[13:0]) == tx_a_end ||
          $past(tx_addr_reg[13:0]) == tx_b_end_m;
  endproperty
  property p_rx_hold;
    !rx_put && !avs_write && !$past(rx_put) && !$past(avs_write)
      |=> $stable(rx_addr_reg);
  endproperty
  property p_rx_base;
    rx_addr_reg[31:14] == 18'h08000;
  endproperty
  property p_tx_base;
    tx_addr_reg[31:14] == 18'h08000;
  endproperty
  property p_rx_unload;
    $fell(rx_avail) |-> $past(rx_put) || $past(avs_write);
  endproperty

  a_first_wait: assert property (p_first_wait)
    else $error("waitrequest low in first request cycle");
  a_one_wait: assert property (p_one_wait)
    else $error("more than one wait state");
  a_after_rst: assert property (p_after_rst)
    else $error("pointers not at reset state");
  a_rx_step: assert property (p_rx_step)
    else $error("receive address did not step by one");
  a_tx_step: assert property (p_tx_step)
    else $error("transmit address did not step by one");
  a_rx_hold: assert property (p_rx_hold)
    else $error("receive address moved without cause");
  a_rx_base: assert property (p_rx_base)
    else $error("receive address upper bits wrong");
  a_tx_base: assert property (p_tx_base)
    else $error("transmit address upper bits wrong");
  a_rx_unload: assert property (p_rx_unload)
    else $error("receive buffer unloaded without cause");

  c_rx: cover property (rx_put && rx_avail);
  c_tx: cover property (tx_take && tx_avail);
  c_unload: cover property ($fell(rx_avail));
endmodule

bind serial_dma_pointers serial_dma_pointers_asserts #(.FW(FW)) u_chk (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .rx_put(rx_put),
  .rx_avail(rx_avail), .rx_addr_reg(rx_addr_reg), .tx_take(tx_take),
  .tx_avail(tx_avail), .tx_addr_reg(tx_addr_reg), .tx_a_end(tx_a_end));

// ==== tb/serial_dma_buffer_pointers_test.sv ====
`include "dma_ptr_map.vh"
module serial_dma_buffer_pointers_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, rd, wr, rx_en, tx_en, slow, rx_put, tx_take;
  logic        wt, rx_avail, tx_avail;
  logic [31:0] addr, wdata, rdata, q, rx_addr, tx_addr;
  logic [13:0] ta_s, ta_e, tb_s;
  int          fails, checks;

  serial_dma_pointers u_dut (.clk(clk), .rst(rst), .avs_address(addr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
    .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(wt),
    .rx_put(rx_put), .rx_avail(rx_avail), .rx_addr_reg(rx_addr),
    .tx_take(tx_take), .tx_avail(tx_avail), .tx_addr_reg(tx_addr),
    .tx_a_start(ta_s), .tx_a_end(ta_e), .tx_b_start(tb_s));
  serial_side_model u_far (.clk(clk), .rst(rst), .rx_en(rx_en),
    .tx_en(tx_en), .slow(slow), .rx_avail(rx_avail), .tx_avail(tx_avail),
    .rx_put(rx_put), .tx_take(tx_take));

  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  // One Avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [31:0] a, d);
    int i;
    @(posedge clk);
    addr <= a; wdata <= d; wr <= w; rd <= !w;
    i = 0;
    do begin @(posedge clk); i++; end while (wt !== 1'b0 && i < 20);
    if (i >= 20) begin fails++; results; end
    q = rdata;
    wr <= 0; rd <= 0;
  endtask
  task rchk(input logic [31:0] a, e);
    bus(0, a, 0);
    chk(q, e);
  endtask
  // Counts accepted bytes itself, so the stop edge is never a race
  task wait_cnt(input bit tx, input int t);
    int i, n;
    n = 0;
    for (i = 0; i < 300 && n < t; i++) begin
      @(posedge clk);
      if (tx ? (tx_take && tx_avail) : (rx_put && rx_avail)) n++;
    end
    if (n < t) begin fails++; results; end
    rx_en <= 0; tx_en <= 0;
    repeat (4) @(posedge clk);
  endtask

  task regs_reset;
    rchk(`ADDR_RX_A_START, `RAM_BASE);
    rchk(`ADDR_RX_B_START, `RAM_BASE);
    rchk(`ADDR_RX_A_END, `RAM_BASE);
    rchk(`ADDR_RX_B_END, `RAM_BASE);
    rchk(`ADDR_TX_B_END, `RAM_BASE);
    rchk(`ADDR_RX_A_OFFSET, 32'h0);
    rchk(`ADDR_RX_B_OFFSET, 32'h0);
    rchk(`ADDR_TX_OFFSET, 32'h0);
    rchk(32'h4000C810, 32'h0);
  endtask
  task regs_rw;
    logic [31:0] a[5];
    a = '{`ADDR_RX_A_START, `ADDR_RX_A_END, `ADDR_RX_B_START,
          `ADDR_RX_B_END, `ADDR_TX_B_END};
    for (int i = 0; i < 5; i++) bus(1, a[i], 32'hFFFFEAA0 + i);
    for (int i = 0; i < 5; i++) rchk(a[i], 32'h20002AA0 + i);
    bus(1, `ADDR_TX_OFFSET, 32'h55);
    rchk(`ADDR_TX_OFFSET, 32'h0);
  endtask
  task rx_flow(input logic s);
    slow <= s;
    bus(1, `ADDR_RX_A_START, 32'h100);
    bus(1, `ADDR_RX_A_END, 32'h103);
    bus(1, `ADDR_RX_B_START, 32'h200);
    bus(1, `ADDR_RX_B_END, 32'h201);
    bus(1, `ADDR_RX_A_OFFSET, 32'h7);
    bus(1, `ADDR_RX_B_OFFSET, 32'h9);
    rchk(`ADDR_RX_A_OFFSET, 32'h0);
    rchk(`ADDR_DMA_STATUS, 32'h3);
    chk(rx_addr, 32'h20000100);
    rx_en <= 1;
    wait_cnt(0, 6);
    chk(rx_avail, 1'b0);
    rchk(`ADDR_RX_A_OFFSET, 32'h4);
    rchk(`ADDR_RX_B_OFFSET, 32'h2);
  endtask
  task tx_flow;
    // Alternate takes so a stop always lands between bytes
    slow <= 1;
    ta_s <= 14'h10; ta_e <= 14'h12; tb_s <= 14'h30;
    bus(1, `ADDR_TX_B_END, 32'h31);
    bus(1, `ADDR_DMA_CTRL, 32'hC);
    chk(tx_addr, 32'h20000010);
    tx_en <= 1;
    wait_cnt(1, 2);
    rchk(`ADDR_TX_OFFSET, 32'h2);
    tx_en <= 1;
    wait_cnt(1, 3);
    chk(tx_avail, 1'b0);
    rchk(`ADDR_TX_OFFSET, 32'h0);
  endtask
  task dma_reset;
    bus(1, `ADDR_RX_A_OFFSET, 32'h1);
    rx_en <= 1;
    wait_cnt(0, 2);
    rchk(`ADDR_RX_A_OFFSET, 32'h2);
    bus(1, `ADDR_DMA_CTRL, 32'h10);
    rchk(`ADDR_RX_A_OFFSET, 32'h0);
    chk(rx_avail, 1'b0);
  endtask

  initial begin
    rst = 1; rd = 0; wr = 0; addr = 0; wdata = 0; rx_en = 0; tx_en = 0;
    slow = 0; ta_s = 0; ta_e = 0; tb_s = 0;
    repeat (6) @(posedge clk);
    rst <= 0;
    regs_reset;
    regs_rw;
    rx_flow(0);
    rx_flow(1);
    tx_flow;
    dma_reset;
    results;
  end
endmodule
